//--- logic/upp_defines.vh
`ifndef UPP_DEFINES_VH
`define UPP_DEFINES_VH

// Internal register space addresses
`define UPP_ADDR_LOW_DATA    8'h90
`define UPP_ADDR_LOW_DIR     8'h91
`define UPP_ADDR_HIGH_DATA   8'ha0
`define UPP_ADDR_HIGH_DIR    8'ha1

// Extended register space addresses of the routing words
`define UPP_ADDR_ROUTE_A     16'hff90
`define UPP_ADDR_ROUTE_B     16'hff91
`define UPP_ADDR_ROUTE_C     16'hff92
`define UPP_ADDR_ROUTE_D     16'hff93

// Pin counts and field layout
`define UPP_NUM_PINS         9
`define UPP_NUM_ROUTED       8
`define UPP_SEL_W            3
`define UPP_SEL_HI_LSB       4
`define UPP_ROUTE_REG_W      8

// Reset values
`define UPP_RST_BYTE         8'h00
`define UPP_RST_PINS         9'h000
`define UPP_RST_ROUTE        32'h0000_0000
`define UPP_PULL_ON          1'b1

// Resource selection codes
`define UPP_SEL_TIMER0       3'h2
`define UPP_SEL_TIMER1       3'h3
`define UPP_SEL_IRQ0_HI      3'h4
`define UPP_SEL_IRQ1_HI      3'h5
`define UPP_SEL_IRQ0_LO      3'h6
`define UPP_SEL_IRQ1_LO      3'h7

`endif

//--- logic/upp_user_pin_port.v
`timescale 1ns/1ps
`default_nettype none
`include "upp_defines.vh"

module upp_user_pin_port (
  input  wire        mclk_i,
  input  wire        rst_i,
  input  wire [7:0]  sfr_addr_i,
  input  wire        sfr_wr_i,
  input  wire [7:0]  sfr_wdata_i,
  output reg  [7:0]  sfr_rdata_o,
  input  wire [15:0] xram_addr_i,
  input  wire        xram_wr_i,
  input  wire [7:0]  xram_wdata_i,
  output reg  [7:0]  xram_rdata_o,
  input  wire        ext_irq0_type_i,
  input  wire        ext_irq1_type_i,
  input  wire [8:0]  user_pin_i,
  output reg  [8:0]  user_pin_o,
  output reg  [8:0]  user_pin_oe_o,
  output reg  [8:0]  user_pin_pullup_o,
  output reg         timer_zero_gate_o,
  output reg         timer_one_gate_o,
  output reg         ext_irq0_o,
  output reg         ext_irq1_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Register contents and sampled pin levels
  reg  [8:0]  data_q;      // Output data per pin
  reg  [8:0]  dir_q;       // 1 = output
  reg         pull_low_q;  // Pull-up still active on pins 0-7
  reg         pull_high_q; // Pull-up still active on pin 8
  reg  [31:0] route_q;     // Four routing registers packed
  reg  [8:0]  pin_q;       // Sampled pin levels
  reg         irq0_lvl_q;  // Combined interrupt 0 term, one cycle late
  reg         irq1_lvl_q;  // Combined interrupt 1 term, one cycle late

  // Next values of the registered outputs
  reg  [7:0]  sfr_rdata_d;
  reg  [7:0]  xram_rdata_d;
  reg  [8:0]  pullup_d;
  reg         ext_irq0_d;
  reg         ext_irq1_d;

  // Write strobes of the mapped internal registers
  wire        wr_low_data  = sfr_wr_i && (sfr_addr_i == `UPP_ADDR_LOW_DATA);
  wire        wr_low_dir   = sfr_wr_i && (sfr_addr_i == `UPP_ADDR_LOW_DIR);
  wire        wr_high_data = sfr_wr_i && (sfr_addr_i == `UPP_ADDR_HIGH_DATA);
  wire        wr_high_dir  = sfr_wr_i && (sfr_addr_i == `UPP_ADDR_HIGH_DIR);

  // Write strobes of the routing registers in the extended space
  wire        wr_route_a   = xram_wr_i && (xram_addr_i == `UPP_ADDR_ROUTE_A);
  wire        wr_route_b   = xram_wr_i && (xram_addr_i == `UPP_ADDR_ROUTE_B);
  wire        wr_route_c   = xram_wr_i && (xram_addr_i == `UPP_ADDR_ROUTE_C);
  wire        wr_route_d   = xram_wr_i && (xram_addr_i == `UPP_ADDR_ROUTE_D);

  // ----------------------------------------------------------------
  // Per-pin resource decode
  // ----------------------------------------------------------------
  wire [7:0]  hit_tmr0;
  wire [7:0]  hit_tmr1;
  wire [7:0]  hit_i0;
  wire [7:0]  hit_i1;

  genvar g;
  generate
    for (g = 0; g < `UPP_NUM_ROUTED; g = g + 1) begin : g_route
      // Even pin in low field, odd pin in high field of its register
      wire [2:0] sel = route_q[(g/2)*`UPP_ROUTE_REG_W + (g%2)*`UPP_SEL_HI_LSB +: `UPP_SEL_W];
      assign hit_tmr0[g] = (sel == `UPP_SEL_TIMER0) & pin_q[g];
      assign hit_tmr1[g] = (sel == `UPP_SEL_TIMER1) & pin_q[g];
      assign hit_i0[g] = ((sel == `UPP_SEL_IRQ0_HI) & pin_q[g]) |
                         ((sel == `UPP_SEL_IRQ0_LO) & ~pin_q[g]);
      assign hit_i1[g] = ((sel == `UPP_SEL_IRQ1_HI) & pin_q[g]) |
                         ((sel == `UPP_SEL_IRQ1_LO) & ~pin_q[g]);
    end
  endgenerate

  // Pin 8 never enters the routing decode
  wire        irq0_lvl = |hit_i0;
  wire        irq1_lvl = |hit_i1;

  // Rising edge of each combined term, used in edge mode
  wire        irq0_rise = irq0_lvl & ~irq0_lvl_q;
  wire        irq1_rise = irq1_lvl & ~irq1_lvl_q;

  // ----------------------------------------------------------------
  // Data read-back values
  // ----------------------------------------------------------------
  // Output pins read their data bit, input pins the sampled level
  wire [8:0]  pin_view = (dir_q & data_q) | (~dir_q & pin_q);

  // ----------------------------------------------------------------
  // Next values of the registered outputs
  // ----------------------------------------------------------------
  // Pull-up only on input pins of a group not yet configured
  always @* begin
    pullup_d = {pull_high_q, {`UPP_NUM_ROUTED{pull_low_q}}} & ~dir_q;
  end

  // Type bit set: rising-edge pulse; clear: level
  always @* begin
    ext_irq0_d = ext_irq0_type_i ? irq0_rise : irq0_lvl;
    ext_irq1_d = ext_irq1_type_i ? irq1_rise : irq1_lvl;
  end

  // Internal register read mux; unmapped reads as zero
  always @* begin
    case (sfr_addr_i)
      `UPP_ADDR_LOW_DATA:  sfr_rdata_d = pin_view[7:0];
      `UPP_ADDR_LOW_DIR:   sfr_rdata_d = dir_q[7:0];
      `UPP_ADDR_HIGH_DATA: sfr_rdata_d = {7'h00, pin_view[8]};
      `UPP_ADDR_HIGH_DIR:  sfr_rdata_d = {7'h00, dir_q[8]};
      default:             sfr_rdata_d = `UPP_RST_BYTE;
    endcase
  end

  // Extended register read mux; unmapped reads as zero
  always @* begin
    case (xram_addr_i)
      `UPP_ADDR_ROUTE_A: xram_rdata_d = route_q[7:0];
      `UPP_ADDR_ROUTE_B: xram_rdata_d = route_q[15:8];
      `UPP_ADDR_ROUTE_C: xram_rdata_d = route_q[23:16];
      `UPP_ADDR_ROUTE_D: xram_rdata_d = route_q[31:24];
      default:           xram_rdata_d = `UPP_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes and pin sampling
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      data_q      <= `UPP_RST_PINS;
      dir_q       <= `UPP_RST_PINS; // All inputs
      pull_low_q  <= `UPP_PULL_ON;
      pull_high_q <= `UPP_PULL_ON;
      route_q     <= `UPP_RST_ROUTE;
      pin_q       <= `UPP_RST_PINS;
      irq0_lvl_q  <= 1'b0;
      irq1_lvl_q  <= 1'b0;
    end else begin
      // Pins sampled every cycle
      pin_q      <= user_pin_i;
      irq0_lvl_q <= irq0_lvl;
      irq1_lvl_q <= irq1_lvl;
      if (wr_low_data) begin
        data_q[7:0] <= sfr_wdata_i;
      end
      if (wr_high_data) begin
        data_q[8] <= sfr_wdata_i[0];
      end
      if (wr_low_dir) begin
        dir_q[7:0] <= sfr_wdata_i; // Independent bit per pin
        pull_low_q <= 1'b0;
      end
      if (wr_high_dir) begin
        dir_q[8]    <= sfr_wdata_i[0];
        pull_high_q <= 1'b0;
      end
      // Routing registers; other extended addresses ignored
      if (wr_route_a) begin
        route_q[7:0] <= xram_wdata_i;
      end
      if (wr_route_b) begin
        route_q[15:8] <= xram_wdata_i;
      end
      if (wr_route_c) begin
        route_q[23:16] <= xram_wdata_i;
      end
      if (wr_route_d) begin
        route_q[31:24] <= xram_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all registered
  // ----------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (rst_i) begin
      sfr_rdata_o       <= `UPP_RST_BYTE;
      xram_rdata_o      <= `UPP_RST_BYTE;
      user_pin_o        <= `UPP_RST_PINS;
      user_pin_oe_o     <= `UPP_RST_PINS;
      user_pin_pullup_o <= {`UPP_NUM_PINS{`UPP_PULL_ON}};
      timer_zero_gate_o <= 1'b0;
      timer_one_gate_o  <= 1'b0;
      ext_irq0_o        <= 1'b0;
      ext_irq1_o        <= 1'b0;
    end else begin
      // Pins, pull-ups and resource outputs
      user_pin_o        <= data_q;
      user_pin_oe_o     <= dir_q;
      user_pin_pullup_o <= pullup_d;
      timer_zero_gate_o <= |hit_tmr0;
      timer_one_gate_o  <= |hit_tmr1;
      ext_irq0_o        <= ext_irq0_d;
      ext_irq1_o        <= ext_irq1_d;

      // Read data, one cycle after the address
      sfr_rdata_o       <= sfr_rdata_d;
      xram_rdata_o      <= xram_rdata_d;
    end
  end

endmodule // upp_user_pin_port

`default_nettype wire

//--- testbench/upp_pins_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port checker for the user pin block
module upp_pins_props (
  input wire logic       mclk_i, rst_i, sfr_wr_i,
  input wire logic       ext_irq0_type_i, ext_irq1_type_i, ext_irq0_o, ext_irq1_o,
  input wire logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o,
  input wire logic [8:0] user_pin_o, user_pin_oe_o, user_pin_pullup_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // Write taken at one edge
  sequence s_wr(logic [7:0] a); sfr_wr_i && sfr_addr_i == a; endsequence
  property p_rst; $fell(rst_i) |-> !user_pin_oe_o && user_pin_pullup_o == 9'h1ff; endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_dlo;
    s_wr(8'h91) |-> ##2 user_pin_oe_o[7:0] == $past(sfr_wdata_i, 2) && !user_pin_pullup_o[7:0];
  endproperty
  a_dlo: assert property (p_dlo) else $error("low direction");
  property p_dhi;
    s_wr(8'ha1) |-> ##2 user_pin_oe_o[8] == $past(sfr_wdata_i[0], 2) && !user_pin_pullup_o[8];
  endproperty
  a_dhi: assert property (p_dhi) else $error("high direction");
  property p_olo; s_wr(8'h90) |-> ##2 user_pin_o[7:0] == $past(sfr_wdata_i, 2); endproperty
  a_olo: assert property (p_olo) else $error("low data");
  property p_pu; (user_pin_pullup_o & user_pin_oe_o) == 9'h000; endproperty
  a_pu: assert property (p_pu) else $error("pull on output");
  property p_sun;
    !(sfr_addr_i inside {8'h90, 8'h91, 8'ha0, 8'ha1}) |=> sfr_rdata_o == 8'h00;
  endproperty
  a_sun: assert property (p_sun) else $error("unmapped read");
  property p_e0; ext_irq0_type_i [*3] ##0 ext_irq0_o |=> !ext_irq0_o; endproperty
  a_e0: assert property (p_e0) else $error("irq0 pulse");
  property p_e1; ext_irq1_type_i [*3] ##0 ext_irq1_o |=> !ext_irq1_o; endproperty
  a_e1: assert property (p_e1) else $error("irq1 pulse");
endmodule // upp_pins_props
bind upp_user_pin_port upp_pins_props upp_pins_props_i (.mclk_i, .rst_i, .sfr_wr_i,
  .ext_irq0_type_i, .ext_irq1_type_i, .ext_irq0_o, .ext_irq1_o, .sfr_addr_i,
  .sfr_wdata_i, .sfr_rdata_o, .user_pin_o, .user_pin_oe_o, .user_pin_pullup_o);
`default_nettype wire

//--- testbench/upp_pin_partner.sv
`timescale 1ns/1ps
`default_nettype none
// Board side of the nine user pins
module upp_pin_partner (
  input  wire logic       mclk_i,
  input  wire logic [8:0] oe_i, out_i, pull_i, drv_i, val_i,
  output var  logic [8:0] pin_o
);
  logic [8:0] flt_q = 9'h0aa;
  // Undriven pins wander each cycle
  always @(posedge mclk_i) flt_q <= ~flt_q;
  // Block drive, then board drive, then pull-up, else floating
  assign pin_o = (oe_i & out_i) | (~oe_i & drv_i & val_i)
               | (~oe_i & ~drv_i & (pull_i | flt_q));
endmodule // upp_pin_partner
`default_nettype wire

//--- testbench/test_upp_user_pin_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "upp_defines.vh"
module test_upp_user_pin_port;
  logic        clk = 0, rst = 1, sw = 0, xw = 0, tg0, tg1, q0, q1;
  logic [1:0]  ty = 0;
  logic [7:0]  sa = 0, sd = 0, xd = 0, sr, xr, rb;
  logic [15:0] xa = 0;
  logic [8:0]  pin, po, oe, pu, drv = 0, val = 0, dir, dat, e, n;
  logic [31:0] rt;
  int          error_cnt = 0, check_count = 0;
  upp_user_pin_port upp_user_pin_port_i (.mclk_i(clk), .rst_i(rst), .sfr_addr_i(sa),
    .sfr_wr_i(sw), .sfr_wdata_i(sd), .sfr_rdata_o(sr), .xram_addr_i(xa), .xram_wr_i(xw),
    .xram_wdata_i(xd), .xram_rdata_o(xr), .ext_irq0_type_i(ty[0]), .ext_irq1_type_i(ty[1]),
    .user_pin_i(pin), .user_pin_o(po), .user_pin_oe_o(oe), .user_pin_pullup_o(pu),
    .timer_zero_gate_o(tg0), .timer_one_gate_o(tg1), .ext_irq0_o(q0), .ext_irq1_o(q1));
  upp_pin_partner upp_pin_partner_i (.mclk_i(clk), .oe_i(oe), .out_i(po), .pull_i(pu),
    .drv_i(drv), .val_i(val), .pin_o(pin));
  initial forever #25 clk = ~clk;
  initial begin #400000; error_cnt++; test_done; end
  task test_done;
    if (error_cnt == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [8:0] ex, got);
    check_count++;
    if (got !== ex) begin error_cnt++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end
  endtask
  task wt(input int c); repeat (c) @(negedge clk); endtask
  // Writes go to mapped places only, unused bits zero
  task wr(input bit x, input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    if (x) begin xa = a; xd = d; xw = 1; end else begin sa = a[7:0]; sd = d; sw = 1; end
    @(negedge clk); sw = 0; xw = 0;
  endtask
  task rd(input bit x, input logic [15:0] a, output logic [7:0] d);
    @(negedge clk); xa = a; sa = a[7:0];
    @(negedge clk); d = x ? xr : sr;
  endtask
  task rst_chk;
    rst = 1; wt(3); rst = 0; wt(1);
    chk("oe", 9'h000, oe); chk("pull", 9'h1ff, pu);
  endtask
  function logic sel(logic [31:0] r, logic [8:0] p, logic [2:0] c);
    sel = 0;
    for (int k = 0; k < 8; k++) if (r[4*k +: 3] == c) sel = sel | p[k];
  endfunction
  initial begin
    void'($urandom(32'hf9db3322));
    rst_chk;
    rd(0, `UPP_ADDR_LOW_DATA, rb); chk("rd_pull", 9'h0ff, rb);
    wr(0, `UPP_ADDR_LOW_DIR, 8'h00); wt(3); chk("pull_grp", 9'h100, pu);
    for (int i = 0; i < 6; i++) begin
      dir = 9'($urandom); dat = 9'($urandom); val = 9'($urandom); drv = ~dir;
      wr(0, `UPP_ADDR_LOW_DIR, dir[7:0]); wr(0, `UPP_ADDR_HIGH_DIR, {7'h00, dir[8]});
      wr(0, `UPP_ADDR_LOW_DATA, dat[7:0]); wr(0, `UPP_ADDR_HIGH_DATA, {7'h00, dat[8]});
      wt(3); e = (dat & dir) | (val & ~dir);
      chk("oe", dir, oe); chk("pull", 9'h000, pu); chk("out", dat, po);
      rd(0, `UPP_ADDR_LOW_DATA, rb); chk("rd_lo", {1'b0, e[7:0]}, rb);
      rd(0, `UPP_ADDR_HIGH_DATA, rb); chk("rd_hi", {8'h00, e[8]}, rb);
    end
    rst_chk;
    wr(0, `UPP_ADDR_LOW_DIR, 8'h00); wr(0, `UPP_ADDR_HIGH_DIR, 8'h00); drv = 9'h1ff;
    for (int i = 0; i < 40; i++) begin
      rt = $urandom & 32'h7777_7777;
      for (int k = 0; k < 4; k++) begin
        wr(1, `UPP_ADDR_ROUTE_A + 16'(k), rt[8*k +: 8]);
        rd(1, `UPP_ADDR_ROUTE_A + 16'(k), rb); chk("route", {1'b0, rt[8*k +: 8]}, rb);
      end
      val = 9'($urandom); ty = 2'($urandom); wt(4);
      chk("tmr0", sel(rt, val, `UPP_SEL_TIMER0), tg0);
      chk("tmr1", sel(rt, val, `UPP_SEL_TIMER1), tg1);
      e[0] = sel(rt, val, `UPP_SEL_IRQ0_HI) | sel(rt, ~val, `UPP_SEL_IRQ0_LO);
      e[1] = sel(rt, val, `UPP_SEL_IRQ1_HI) | sel(rt, ~val, `UPP_SEL_IRQ1_LO);
      chk("irq0", e[0] & ~ty[0], q0); chk("irq1", e[1] & ~ty[1], q1);
    end
    ty = 2'b11; val = 9'h002;
    for (int k = 0; k < 4; k++) wr(1, `UPP_ADDR_ROUTE_A + 16'(k), k == 0 ? 8'h74 : 8'h00);
    wt(4); val = 9'h001; n = 0; e = 0;
    repeat (6) begin @(negedge clk); n = n + q0; e = e + q1; end
    chk("pulse0", 9'h001, n); chk("pulse1", 9'h001, e);
    test_done;
  end
endmodule // test_upp_user_pin_port
`default_nettype wire
